// [rtl/erb_pkg.sv]
// Package and lane-merge leaf for the embedded RAM block
`default_nettype none

package erb_pkg;
  localparam int SMALL_BITS      = 4608;
  localparam int LARGE_BITS      = 589824;
  localparam int LANE_W          = 9;
  localparam int SMALL_UNITS     = SMALL_BITS / LANE_W;
  localparam int LARGE_UNITS     = LARGE_BITS / LANE_W;
  localparam int SMALL_MAX_LANES = 4;
  localparam int LARGE_MAX_LANES = 16;
  localparam int NUM_LANES       = 16;
  localparam int DATA_W          = 144;
  localparam int ADDR_W          = 16;
  localparam int WID_W           = 4;
  localparam logic [8:0] ROM_SEED = 9'h0a5;

  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_SIMPLE_DUAL,
    MODE_TRUE_DUAL
  } erb_mode_t;

  typedef enum logic [WID_W-1:0] {
    WID_1, WID_2, WID_4, WID_8, WID_9, WID_16, WID_18,
    WID_32, WID_36, WID_64, WID_72, WID_128, WID_144
  } erb_width_t;

  // Byte lanes per word; zero for the sub-byte shapes
  function automatic logic [4:0] wid_lanes(input erb_width_t w);
    case (w)
      WID_8, WID_9:     wid_lanes = 5'h1;
      WID_16, WID_18:   wid_lanes = 5'h2;
      WID_32, WID_36:   wid_lanes = 5'h4;
      WID_64, WID_72:   wid_lanes = 5'h8;
      WID_128, WID_144: wid_lanes = 5'h10;
      default:          wid_lanes = 5'h0;
    endcase
  endfunction

  function automatic logic [2:0] wid_subbits(input erb_width_t w);
    case (w)
      WID_1:   wid_subbits = 3'h1;
      WID_2:   wid_subbits = 3'h2;
      WID_4:   wid_subbits = 3'h4;
      default: wid_subbits = 3'h0;
    endcase
  endfunction

  function automatic logic wid_parity(input erb_width_t w);
    wid_parity = (w == WID_9) || (w == WID_18) || (w == WID_36) ||
                 (w == WID_72) || (w == WID_144);
  endfunction

  // Fixed ROM image, a pure function of the lane index
  function automatic logic [8:0] rom_lane(input logic [ADDR_W-1:0] idx);
    rom_lane = idx[8:0] ^ ROM_SEED;
  endfunction
endpackage

module erb_lane (
  input  wire logic [8:0] i_old,
  input  wire logic       i_en,
  input  wire logic       i_sub_mode,
  input  wire logic       i_par,
  input  wire logic [8:0] i_mask,
  input  wire logic [8:0] i_dsub,
  input  wire logic [8:0] i_dlane,
  input  wire logic [7:0] i_dbyte,
  output logic      [8:0] o_mrg
);
  wire [8:0] sub_new  = (i_old & ~i_mask) | (i_dsub & i_mask);
  // Plain byte widths leave the parity bit as stored
  wire [8:0] byte_new = i_par ? i_dlane : {i_old[8], i_dbyte};

  assign o_mrg = !i_en ? i_old : (i_sub_mode ? sub_new : byte_new);
endmodule

`default_nettype wire

// [rtl/erb_ram_block.sv]
// Embedded RAM block, small or large by parameter, one or two ports
//
// Notes on behaviour
// - Small block holds 4,608 bits, large block 589,824 bits, parity included.
// - Small block shapes run from 4K by 1 to 128 by 36.
// - Large block shapes run from 64K by 8 to 4K by 144.
// - Single, simple dual and true dual port; ports may differ in width.
// - Small block as ROM reads its fixed image from power-up, no writes.
// - RAM contents and output registers are undefined after power-up.
// - RAM contents are never preloaded; only writes fill them.
// - Same-port read and write of one address returns the new data.
// - Cross-port read of a written address: small gives old, large unknown.
`default_nettype none

module erb_ram_block #(
  parameter bit IS_LARGE = 1'b0
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_srst,
  input  wire erb_pkg::erb_mode_t     i_mode,
  input  wire logic                   i_rom_en,
  input  wire logic [15:0]            i_a_addr,
  input  wire erb_pkg::erb_width_t    i_a_wid,
  input  wire logic [143:0]           i_a_wdata,
  input  wire logic [15:0]            i_a_be,
  input  wire logic                   i_a_we,
  input  wire logic                   i_a_re,
  input  wire logic                   i_a_clr,
  output logic      [143:0]           o_a_rdata,
  input  wire logic [15:0]            i_b_addr,
  input  wire erb_pkg::erb_width_t    i_b_wid,
  input  wire logic [143:0]           i_b_wdata,
  input  wire logic [15:0]            i_b_be,
  input  wire logic                   i_b_we,
  input  wire logic                   i_b_re,
  input  wire logic                   i_b_clr,
  output logic      [143:0]           o_b_rdata
);
  import erb_pkg::*;

  localparam int          UNITS   = IS_LARGE ? LARGE_UNITS : SMALL_UNITS;
  localparam int          UW      = $clog2(UNITS);
  localparam logic [20:0] UNITS_W = 21'(UNITS);
  localparam logic [4:0]  MAX_L   = IS_LARGE ? 5'(LARGE_MAX_LANES) : 5'(SMALL_MAX_LANES);
  localparam bit          SUB_OK  = !IS_LARGE;
  localparam bit          ROM_OK  = !IS_LARGE;
  localparam bit          MIX_OLD = !IS_LARGE;

  // No reset and no initial image: power-up contents are whatever the cells hold
  logic [8:0] mem_q [UNITS];

  wire [15:0]        addr  [2];
  wire erb_width_t   wid   [2];
  wire [143:0]       wdat  [2];
  wire [15:0]        be    [2];
  wire [1:0]         we;
  wire [1:0]         re;
  wire [1:0]         clr;
  wire [1:0]         wr_ok;
  wire [1:0]         rd_ok;
  wire [1:0]         mix;
  wire [20:0]        ub    [2];
  wire [4:0]         sp    [2];
  wire [4:0]         lanes [2];
  wire [15:0]        wen   [2];
  wire [8:0]         mrg   [2][NUM_LANES];
  wire [UW-1:0]      idx   [2][NUM_LANES];
  logic [143:0]      rdw   [2];
  logic [143:0]      rd_reg[2];

  assign addr[0] = i_a_addr;
  assign addr[1] = i_b_addr;
  assign wid[0]  = i_a_wid;
  assign wid[1]  = i_b_wid;
  assign wdat[0] = i_a_wdata;
  assign wdat[1] = i_b_wdata;
  assign be[0]   = i_a_be;
  assign be[1]   = i_b_be;
  assign we      = {i_b_we, i_a_we};
  assign re      = {i_b_re, i_a_re};
  assign clr     = {i_b_clr, i_a_clr};

  // Port A always writes; B writes only in true dual, reads in both dual modes
  wire wr_mode_b = (i_mode == MODE_TRUE_DUAL);
  wire rd_mode_a = (i_mode != MODE_SIMPLE_DUAL);
  wire rd_mode_b = (i_mode != MODE_SINGLE);
  wire rom_on    = ROM_OK && i_rom_en;

  for (genvar p = 0; p < 2; p++) begin : g_port
    wire [2:0]  sub      = wid_subbits(wid[p]);
    wire        par      = wid_parity(wid[p]);
    wire        sub_mode = (lanes[p] == 5'h0);
    wire [1:0]  shf      = (sub == 3'h1) ? 2'h3 : ((sub == 3'h2) ? 2'h2 : 2'h1);
    wire [2:0]  off      = (sub == 3'h1) ? addr[p][2:0] :
                           ((sub == 3'h2) ? {addr[p][1:0], 1'b0} : {addr[p][0], 2'h0});
    wire [20:0] prod     = {5'h0, addr[p]} * {16'h0, lanes[p]};
    wire [20:0] uend     = ub[p] + {16'h0, sp[p]};
    wire        legal    = sub_mode ? (SUB_OK && (sub != 3'h0)) : (lanes[p] <= MAX_L);
    wire        fits     = (uend <= UNITS_W);
    wire        port_wr  = (p == 0) ? 1'b1 : wr_mode_b;
    wire        port_rd  = (p == 0) ? rd_mode_a : rd_mode_b;
    wire [8:0]  lmask    = (9'h1 << sub) - 9'h1;
    wire [8:0]  smask    = lmask << off;
    wire [8:0]  dsub     = {5'h0, wdat[p][3:0]} << off;
    wire [143:0] rd_sel;

    assign lanes[p] = wid_lanes(wid[p]);
    assign ub[p]    = sub_mode ? {5'h0, addr[p] >> shf} : prod;
    assign sp[p]    = sub_mode ? 5'h1 : lanes[p];
    assign wr_ok[p] = we[p] && legal && fits && port_wr && !rom_on;
    assign rd_ok[p] = re[p] && legal && fits && port_rd;

    for (genvar k = 0; k < NUM_LANES; k++) begin : g_lane
      wire       on = sub_mode ? (k == 0) : (5'(k) < lanes[p]);
      wire [8:0] old;

      assign idx[p][k] = UW'(ub[p] + 21'(k));
      assign old       = rom_on ? rom_lane(ADDR_W'(idx[p][k])) : mem_q[idx[p][k]];
      assign wen[p][k] = wr_ok[p] && on && be[p][k];

      erb_lane u_lane (
        .i_old      (old),
        .i_en       (wen[p][k]),
        .i_sub_mode (sub_mode),
        .i_par      (par),
        .i_mask     (smask),
        .i_dsub     (dsub),
        .i_dlane    (wdat[p][9*k +: 9]),
        .i_dbyte    (wdat[p][8*k +: 8]),
        .o_mrg      (mrg[p][k])
      );
    end

    // Other port writing an overlapping lane in this cycle
    assign mix[p] = rd_ok[p] && wr_ok[1-p] &&
                    (ub[p] < ub[1-p] + {16'h0, sp[1-p]}) &&
                    (ub[1-p] < ub[p] + {16'h0, sp[p]});

    // Read through the merged lanes so an own write shows at once
    always_comb begin
      rdw[p] = '0;
      if (sub_mode) begin
        rdw[p][3:0] = 4'((mrg[p][0] >> off) & lmask);
      end else begin
        for (int k = 0; k < NUM_LANES; k++) begin
          if (5'(k) < lanes[p]) begin
            if (par) begin
              rdw[p][9*k +: 9] = mrg[p][k];
            end else begin
              rdw[p][8*k +: 8] = mrg[p][k][7:0];
            end
          end
        end
      end
    end

    // Small block keeps old data (mem not yet updated); large one has no defined answer
    assign rd_sel = (mix[p] && !MIX_OLD) ? {DATA_W{1'bx}} : rdw[p];

    always_ff @(posedge i_clk) begin
      if (i_srst || clr[p]) begin
        rd_reg[p] <= '0;
      end else if (rd_ok[p]) begin
        rd_reg[p] <= rd_sel;
      end
    end
  end

  // Port B is applied last, so it wins a same-lane write collision
  always_ff @(posedge i_clk) begin
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < NUM_LANES; k++) begin
        if (wen[p][k]) begin
          mem_q[idx[p][k]] <= mrg[p][k];
        end
      end
    end
  end

  assign o_a_rdata = rd_reg[0];
  assign o_b_rdata = rd_reg[1];

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  AST_CLR_A: assert property (
    i_a_clr |=> (o_a_rdata == '0)
  ) else $error("Port A clear did not zero its output register");

  AST_SAMEPORT: assert property (
    (wr_ok[0] && rd_ok[0] && i_a_be[0] && i_a_wid == WID_9 && !i_a_clr)
      |=> (o_a_rdata[8:0] == $past(i_a_wdata[8:0]))
  ) else $error("Same-port read during write did not return new data");

  AST_BE_KEEP: assert property (
    (wr_ok[0] && rd_ok[0] && !i_a_be[0] && i_a_wid == WID_9 && !i_a_clr)
      |=> (o_a_rdata[8:0] == $past(g_port[0].g_lane[0].old))
  ) else $error("Disabled byte lane was altered by a write");

  AST_ROM_READ: assert property (
    (rom_on && rd_ok[0] && i_a_wid == WID_9 && !i_a_clr)
      |=> (o_a_rdata[8:0] == rom_lane($past(i_a_addr)))
  ) else $error("ROM read did not return the fixed image");

  AST_MIX_OLD: assert property (
    // An own write on port B shows new data instead, so it is left out here
    (!IS_LARGE && mix[1] && !wen[1][0] && i_b_wid == WID_9 && !i_b_clr)
      |=> (o_b_rdata[8:0] == $past(g_port[1].g_lane[0].old))
  ) else $error("Small block cross-port read did not return old data");

  AST_B_NOWR: assert property (
    (i_mode != MODE_TRUE_DUAL) |-> (wen[1] == 16'h0)
  ) else $error("Port B wrote outside true dual-port mode");

  AST_HOLD: assert property (
    (!rd_ok[0] && !i_a_clr) |=> $stable(o_a_rdata)
  ) else $error("Port A output changed without a read or clear");

  AST_SHAPE: assert property (
    ((IS_LARGE && lanes[0] == 5'h0) || (!IS_LARGE && lanes[0] > 5'h4))
      |-> (!wr_ok[0] && !rd_ok[0])
  ) else $error("Access accepted for a shape this block lacks");

  AST_RESET: assert property (
    @(posedge i_clk) disable iff (1'b0)
    i_srst |=> (o_a_rdata == '0 && o_b_rdata == '0)
  ) else $error("Reset did not zero the output registers");
endmodule

`default_nettype wire

// [verification/erb_user_model.sv]
// Fabric user logic model that drives port B of the RAM block
`default_nettype none

module erb_user_model (
  input  wire logic                 i_clk,
  output logic      [15:0]          o_addr,
  output var erb_pkg::erb_width_t   o_wid,
  output logic      [143:0]         o_wdata,
  output logic      [15:0]          o_be,
  output logic                      o_we,
  output logic                      o_re,
  output logic                      o_clr
);
  timeunit 1ns;
  timeprecision 1ps;
  import erb_pkg::*;

  initial begin
    o_addr  = '0;
    o_wid   = WID_9;
    o_wdata = '0;
    o_be    = '0;
    o_we    = 1'b0;
    o_re    = 1'b0;
    o_clr   = 1'b0;
  end

  // One request held across exactly one rising edge; every read follows a write of that word
  task automatic b_op(input logic [15:0] a, input erb_width_t w, input logic [17:0] d,
                      input logic [1:0] be, input logic we, input logic re);
    @(negedge i_clk);
    o_addr  = a;
    o_wid   = w;
    o_wdata = {126'h0, d};
    o_be    = {14'h0, be};
    o_we    = we;
    o_re    = re;
    @(negedge i_clk);
    o_we    = 1'b0;
    o_re    = 1'b0;
    // Stale data must not look valid once the write is over
    o_wdata = ~o_wdata;
  endtask
endmodule

`default_nettype wire

// [verification/erb_ram_block_tb.sv]
// Self-checking bench for the small RAM block, port B driven by the user model
`default_nettype none

module erb_ram_block_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import erb_pkg::*;

  logic               i_clk;
  logic               i_srst;
  erb_mode_t          mode;
  logic               rom_en;
  logic [15:0]        a_addr;
  erb_width_t         a_wid;
  logic [143:0]       a_wdata;
  logic [15:0]        a_be;
  logic               a_we;
  logic               a_re;
  logic               a_clr;
  logic [143:0]       a_rdata;
  logic [15:0]        b_addr;
  erb_width_t         b_wid;
  logic [143:0]       b_wdata;
  logic [15:0]        b_be;
  logic               b_we;
  logic               b_re;
  logic               b_clr;
  logic [143:0]       b_rdata;
  int                 n_mismatch;
  int                 checks_done;

  erb_ram_block #(.IS_LARGE(1'b0)) u_dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_mode(mode), .i_rom_en(rom_en),
    .i_a_addr(a_addr), .i_a_wid(a_wid), .i_a_wdata(a_wdata), .i_a_be(a_be),
    .i_a_we(a_we), .i_a_re(a_re), .i_a_clr(a_clr), .o_a_rdata(a_rdata),
    .i_b_addr(b_addr), .i_b_wid(b_wid), .i_b_wdata(b_wdata), .i_b_be(b_be),
    .i_b_we(b_we), .i_b_re(b_re), .i_b_clr(b_clr), .o_b_rdata(b_rdata)
  );

  erb_user_model u_user (
    .i_clk(i_clk), .o_addr(b_addr), .o_wid(b_wid), .o_wdata(b_wdata),
    .o_be(b_be), .o_we(b_we), .o_re(b_re), .o_clr(b_clr)
  );

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic summarize;
    $display("Counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Port A request held over one rising edge, released at the next falling edge
  task automatic a_op(input logic [15:0] a, input erb_width_t w, input logic [17:0] d,
                      input logic [1:0] be, input logic we, input logic re, input logic clr);
    @(negedge i_clk);
    a_addr  = a;
    a_wid   = w;
    a_wdata = {126'h0, d};
    a_be    = {14'h0, be};
    a_we    = we;
    a_re    = re;
    a_clr   = clr;
    @(negedge i_clk);
    a_we    = 1'b0;
    a_re    = 1'b0;
    a_clr   = 1'b0;
    a_wdata = ~a_wdata;
  endtask

  task automatic t_same_port;
    mode = MODE_SINGLE;
    a_op(16'h0005, WID_9, 18'h001ab, 2'b01, 1'b1, 1'b1, 1'b0);
    chk({9'h0, a_rdata[8:0]}, 18'h001ab);
    a_op(16'h0005, WID_9, 18'h0, 2'b00, 1'b0, 1'b1, 1'b1);
    chk(a_rdata[17:0], 18'h0);
    a_op(16'h0005, WID_9, 18'h0, 2'b00, 1'b0, 1'b1, 1'b0);
    chk({9'h0, a_rdata[8:0]}, 18'h001ab);
    a_op(16'h0005, WID_9, 18'h000ff, 2'b00, 1'b1, 1'b1, 1'b0);
    chk({9'h0, a_rdata[8:0]}, 18'h001ab);
    $display("test same_port done");
  endtask

  task automatic t_byte_en;
    a_op(16'h0003, WID_18, 18'h3ffff, 2'b11, 1'b1, 1'b0, 1'b0);
    a_op(16'h0003, WID_18, 18'h00012, 2'b01, 1'b1, 1'b1, 1'b0);
    chk(a_rdata[17:0], 18'h3fe12);
    $display("test byte_en done");
  endtask

  // Small block keeps old data on a cross-port collision; unknown would also be legal
  task automatic t_cross_port;
    a_op(16'h0007, WID_9, 18'h00055, 2'b01, 1'b1, 1'b0, 1'b0);
    mode = MODE_SIMPLE_DUAL;
    fork
      a_op(16'h0007, WID_9, 18'h000aa, 2'b01, 1'b1, 1'b0, 1'b0);
      u_user.b_op(16'h0007, WID_9, 18'h0, 2'b00, 1'b0, 1'b1);
    join
    chk({9'h0, b_rdata[8:0]}, 18'h00055);
    u_user.b_op(16'h0007, WID_9, 18'h0, 2'b00, 1'b0, 1'b1);
    chk({9'h0, b_rdata[8:0]}, 18'h000aa);
    // Unit 6 was last written by port A at WID_18, unit 7 at WID_9
    u_user.b_op(16'h0003, WID_18, 18'h0, 2'b00, 1'b0, 1'b1);
    chk(b_rdata[17:0], 18'h15412);
    $display("test cross_port done");
  endtask

  task automatic t_true_dual;
    mode = MODE_TRUE_DUAL;
    u_user.b_op(16'h0014, WID_9, 18'h00133, 2'b01, 1'b1, 1'b0);
    a_op(16'h0014, WID_9, 18'h0, 2'b00, 1'b0, 1'b1, 1'b0);
    chk({9'h0, a_rdata[8:0]}, 18'h00133);
    $display("test true_dual done");
  endtask

  task automatic t_rom;
    mode   = MODE_SINGLE;
    rom_en = 1'b1;
    // The write must be blocked, so the read shows the fixed image
    a_op(16'h0010, WID_9, 18'h00001, 2'b01, 1'b1, 1'b1, 1'b0);
    chk({9'h0, a_rdata[8:0]}, {9'h0, 9'h010 ^ ROM_SEED});
    rom_en = 1'b0;
    $display("test rom done");
  endtask

  // Two nibbles share one unit; a shape the small block lacks is refused
  task automatic t_sub_byte;
    mode = MODE_SINGLE;
    a_op(16'h0041, WID_4, 18'h00009, 2'b01, 1'b1, 1'b0, 1'b0);
    a_op(16'h0040, WID_4, 18'h00006, 2'b01, 1'b1, 1'b0, 1'b0);
    a_op(16'h0020, WID_8, 18'h0, 2'b00, 1'b0, 1'b1, 1'b0);
    chk(a_rdata[17:0], 18'h00096);
    a_op(16'h0041, WID_4, 18'h0, 2'b00, 1'b0, 1'b1, 1'b0);
    chk(a_rdata[17:0], 18'h00009);
    a_op(16'h0000, WID_72, 18'h3ffff, 2'b11, 1'b1, 1'b1, 1'b0);
    chk(a_rdata[17:0], 18'h00009);
    $display("test sub_byte done");
  endtask

  initial begin
    #(100000 * 40);
    n_mismatch++;
    summarize();
  end

  initial begin
    n_mismatch  = 0;
    checks_done = 0;
    i_srst  = 1'b1;
    mode    = MODE_SINGLE;
    rom_en  = 1'b0;
    a_addr  = '0;
    a_wid   = WID_9;
    a_wdata = '0;
    a_be    = '0;
    a_we    = 1'b0;
    a_re    = 1'b0;
    a_clr   = 1'b0;
    // Rising edges are counted: the clock's first step at time zero looks like a falling edge
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    i_srst = 1'b0;
    chk(a_rdata[17:0], 18'h0);
    t_same_port();
    t_byte_en();
    t_cross_port();
    t_true_dual();
    t_rom();
    t_sub_byte();
    summarize();
  end
endmodule

`default_nettype wire
